// >>> design/clock_failure_monitor.sv
// Clock source control with primary and watchdog oscillator failure detection
// What this block does
// - Primary detector may be re-enabled after select write
// - Internal oscillator on at reset, stays until cleared
// - Primary failure raises event, falls back to watchdog
// - Fallback only if watchdog oscillator enabled
// - Primary failure when clock below about 1 kHz
// - Watchdog failure raises event, no source change
// - After watchdog failure, primary detection stops
// - Watchdog failure after 8004 cycles without edge
// - No divider: crystal pin clock passes undivided
// - Option bits choose one of four oscillator modes
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module clock_failure_monitor
	import clock_failure_monitor_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic crystal_input_pin,
	input wire logic precOscClk,
	input wire logic wdogClk,
	input wire logic extClk,
	input wire logic [1:0] xtalModeOption,
	input wire logic crystal_disable_option,
	output logic internal_precision_osc,
	output logic xtalEnable,
	output logic wdogOscEnable,
	output logic [1:0] xtalMode,
	output logic [1:0] activeSource,
	output logic clkFailEvent,
	output logic irq
);
	// Sampled oscillator levels
	logic [3:0] oscMeta;
	logic [3:0] oscSync;
	logic [3:0] oscPrev;
	// Bit order follows the source encoding
	wire [3:0] oscRaw = {extClk, wdogClk, crystal_input_pin, precOscClk};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			always_ff @(posedge clk_sys) begin
				oscMeta[gi] <= oscRaw[gi];
				oscSync[gi] <= oscMeta[gi];
				oscPrev[gi] <= oscSync[gi];
			end
		end
	endgenerate
	wire [3:0] oscEdge = oscSync & ~oscPrev;

	// Registers
	logic [31:0] ctrl;
	logic [1:0] irqStat;
	logic [1:0] irqMask;
	logic fallback;
	logic wdogFailed;
	logic optionTaken;
	wire [1:0] swSel = ctrl[CTRL_SEL_HI:CTRL_SEL_LO];
	wire sysFailEn = ctrl[CTRL_SYSFAIL_EN];
	wire wdFailEn = ctrl[CTRL_WDFAIL_EN];
	wire wdOscEn = ctrl[CTRL_WDOG_OSC_EN];

	// Effective source; fallback overrides software choice
	wire [1:0] next_source = fallback ? SRC_WDOG : swSel;
	wire srcEdge = oscEdge[next_source];

	// Primary detector runs until fallback or until watchdog oscillator is known failed
	logic sysFailPulse;
	logic wdFailPulse;
	wire sysDetEnable = sysFailEn && !fallback && !wdogFailed &&
		!wdFailPulse;
	wire wdDetEnable = wdFailEn && wdOscEn && !wdogFailed;

	edge_watchdog #(.LIMIT(SYSFAIL_CYCLES)) u_sysfail (
		.clk_sys(clk_sys),
		.rst(rst),
		.enable(sysDetEnable),
		.edgeSeen(srcEdge),
		.failPulse(sysFailPulse)
	);

	edge_watchdog #(.LIMIT(WDFAIL_CYCLES)) u_wdfail (
		.clk_sys(clk_sys),
		.rst(rst),
		.enable(wdDetEnable),
		.edgeSeen(oscEdge[SRC_WDOG]),
		.failPulse(wdFailPulse)
	);

	// AXI4-Lite write path
	logic awHeld;
	logic wHeld;
	logic [7:0] awAddr;
	logic [31:0] wData;
	logic [3:0] wStrb;
	wire awTake = s_axi_awvalid && s_axi_awready;
	wire wTake = s_axi_wvalid && s_axi_wready;
	wire haveAw = awHeld || awTake;
	wire haveW = wHeld || wTake;
	wire [7:0] curAw = awHeld ? awAddr : s_axi_awaddr;
	wire [31:0] curW = wHeld ? wData : s_axi_wdata;
	wire [3:0] curS = wHeld ? wStrb : s_axi_wstrb;
	wire doWrite = haveAw && haveW && !s_axi_bvalid;
	wire wrCtrl = doWrite && (curAw == ADDR_CTRL);
	wire wrIrqStat = doWrite && (curAw == ADDR_IRQ_STAT);
	wire wrIrqMask = doWrite && (curAw == ADDR_IRQ_MASK);
	wire wrMapped = (curAw == ADDR_CTRL) || (curAw == ADDR_STATUS) ||
		(curAw == ADDR_IRQ_STAT) || (curAw == ADDR_IRQ_MASK);
	logic [31:0] byteMask;
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			byteMask[8*b +: 8] = {8{curS[b]}};
		end
	end
	wire [31:0] next_ctrl = (ctrl & ~byteMask) | (curW & byteMask);
	wire selWritten = wrCtrl && curS[0];
	// Ready flags registered from next handshake state
	wire next_bvalid = doWrite || (s_axi_bvalid && !s_axi_bready);
	wire next_awReady = !(haveAw && !doWrite) && !next_bvalid;
	wire next_wReady = !(haveW && !doWrite) && !next_bvalid;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddr <= 8'h00;
			wData <= 32'h0000_0000;
			wStrb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end else begin
			if (doWrite) begin
				awHeld <= 1'b0;
				wHeld <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wrMapped ? 2'b00 : 2'b10;
			end else begin
				if (awTake) begin
					awHeld <= 1'b1;
					awAddr <= s_axi_awaddr;
				end
				if (wTake) begin
					wHeld <= 1'b1;
					wData <= s_axi_wdata;
					wStrb <= s_axi_wstrb;
				end
				if (s_axi_bvalid && s_axi_bready) begin
					s_axi_bvalid <= 1'b0;
				end
			end
			s_axi_awready <= next_awReady;
			s_axi_wready <= next_wReady;
		end
	end

	// Control register; internal oscillator enable kept until cleared
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl <= CTRL_RESET;
			optionTaken <= 1'b0;
		end else begin
			if (!optionTaken) begin
				ctrl[CTRL_XTAL_EN] <= !crystal_disable_option;
				optionTaken <= 1'b1;
			end else if (wrCtrl) begin
				ctrl <= next_ctrl & 32'h0000_007F;
			end
		end
	end

	// Fallback and watchdog failure state; select write ends fallback
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			fallback <= 1'b0;
			wdogFailed <= 1'b0;
		end else begin
			if (sysFailPulse && wdOscEn) begin
				fallback <= 1'b1;
			end else if (selWritten) begin
				fallback <= 1'b0;
			end
			if (wdFailPulse) begin
				wdogFailed <= 1'b1;
			end
		end
	end

	// Sticky interrupt status, set wins over write-one-to-clear
	wire [1:0] irqSet = {wdFailPulse, sysFailPulse};
	wire [1:0] irqClr = wrIrqStat ? curW[1:0] : 2'b00;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irqStat <= 2'b00;
			irqMask <= IRQ_MASK_RESET;
			irq <= 1'b0;
			clkFailEvent <= 1'b0;
		end else begin
			irqStat <= (irqStat & ~irqClr) | irqSet;
			if (wrIrqMask) begin
				irqMask <= curW[1:0];
			end
			irq <= |(irqStat & irqMask);
			clkFailEvent <= |irqSet;
		end
	end

	// Read path
	wire [31:0] statusWord = {26'h0, wdogFailed, fallback, 2'b00,
		activeSource};
	logic [31:0] readMux;
	always_comb begin
		case (s_axi_araddr)
			ADDR_CTRL: readMux = ctrl;
			ADDR_STATUS: readMux = statusWord;
			ADDR_IRQ_STAT: readMux = {30'h0, irqStat};
			ADDR_IRQ_MASK: readMux = {30'h0, irqMask};
			default: readMux = 32'h0000_0000;
		endcase
	end
	wire rdMapped = (s_axi_araddr == ADDR_CTRL) ||
		(s_axi_araddr == ADDR_STATUS) ||
		(s_axi_araddr == ADDR_IRQ_STAT) || (s_axi_araddr == ADDR_IRQ_MASK);
	wire arTake = s_axi_arvalid && s_axi_arready;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end else if (arTake) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= readMux;
			s_axi_rresp <= rdMapped ? 2'b00 : 2'b10;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
	wire next_rvalid = arTake || (s_axi_rvalid && !s_axi_rready);
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
		end else begin
			s_axi_arready <= !next_rvalid;
		end
	end

	// Oscillator controls from control register, mode from option bits
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			internal_precision_osc <= 1'b1;
			xtalEnable <= 1'b0;
			wdogOscEnable <= 1'b0;
			xtalMode <= XMODE_MIN_PWR;
			activeSource <= SRC_PREC_OSC;
		end else begin
			internal_precision_osc <= ctrl[CTRL_PREC_OSC_EN];
			xtalEnable <= ctrl[CTRL_XTAL_EN];
			wdogOscEnable <= wdOscEn;
			xtalMode <= xtalModeOption;
			activeSource <= next_source;
		end
	end

	// Checks
	fallback_wdog_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		sysFailPulse && wdOscEn && !selWritten |=> ##1 activeSource == SRC_WDOG)
		else $error("fallback did not select watchdog oscillator");
	no_fallback_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		!wdOscEn && !fallback |=> !fallback)
		else $error("fallback without watchdog oscillator");
	wdfail_nosw_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		wdFailPulse && !sysFailPulse && !selWritten |=> $stable(fallback))
		else $error("watchdog failure changed source");
	primary_dead_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		wdogFailed |-> !sysFailPulse)
		else $error("primary detect after watchdog failure");
	event_pulse_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		(sysFailPulse || wdFailPulse) |=> clkFailEvent)
		else $error("failure event not raised");
	prec_osc_hold_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		!(wrCtrl && !curW[CTRL_PREC_OSC_EN] && curS[0]) &&
		ctrl[CTRL_PREC_OSC_EN] |=> ##1 internal_precision_osc)
		else $error("internal oscillator dropped by itself");
	mode_follow_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		##1 xtalMode == $past(xtalModeOption))
		else $error("oscillator mode not from option bits");
	sticky_set_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		sysFailPulse |=> irqStat[IRQ_SYSFAIL])
		else $error("failure status lost");
	wd_count_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		wdFailPulse |-> $past(wdDetEnable) && !$past(oscEdge[SRC_WDOG]))
		else $error("watchdog failure without missing edge");
	fallback_c: cover property (@(posedge clk_sys) disable iff (rst)
		$rose(fallback));
	wdfail_c: cover property (@(posedge clk_sys) disable iff (rst)
		$rose(wdogFailed));
	irq_c: cover property (@(posedge clk_sys) disable iff (rst) $rose(irq));
endmodule : clock_failure_monitor

// >>> design/clock_failure_monitor_pkg.sv
// Package for the clock failure monitor: register map, fields, counts
package clock_failure_monitor_pkg;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
	// Control register field positions
	localparam int CTRL_PREC_OSC_EN = 0;
	localparam int CTRL_XTAL_EN = 1;
	localparam int CTRL_WDOG_OSC_EN = 2;
	localparam int CTRL_SYSFAIL_EN = 3;
	localparam int CTRL_WDFAIL_EN = 4;
	localparam int CTRL_SEL_LO = 5;
	localparam int CTRL_SEL_HI = 6;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	// Interrupt status bits
	localparam int IRQ_SYSFAIL = 0;
	localparam int IRQ_WDFAIL = 1;
	localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
	// Clock sources
	typedef enum logic [1:0] {
		SRC_PREC_OSC = 2'b00,
		SRC_XTAL = 2'b01,
		SRC_WDOG = 2'b10,
		SRC_EXT = 2'b11
	} clk_src_t;
	// Crystal oscillator modes from option bits
	typedef enum logic [1:0] {
		XMODE_MIN_PWR = 2'b00,
		XMODE_MED_PWR = 2'b01,
		XMODE_MAX_PWR = 2'b10,
		XMODE_RC = 2'b11
	} xtal_mode_t;
	// Primary failure: no selected-clock edge for one period at 1 kHz
	localparam int CLK_MHZ = 125;
	localparam int FAIL_FREQ_HZ = 1000;
	localparam int SYSFAIL_CYCLES = CLK_MHZ * 1000000 / FAIL_FREQ_HZ;
	localparam int WDFAIL_CYCLES = 8004;
endpackage : clock_failure_monitor_pkg

// >>> design/edge_watchdog.sv
// Edge-gap counter: flags failure when no edge within a limit
`timescale 1ns/100ps
module edge_watchdog #(
	parameter int LIMIT = 8004
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic enable,
	input wire logic edgeSeen,
	output logic failPulse
);
	logic [31:0] gapCount;
	wire atLimit = (gapCount == 32'(LIMIT - 1));
	always_ff @(posedge clk_sys) begin
		if (rst || !enable || edgeSeen) begin
			gapCount <= 32'h0000_0000;
			failPulse <= 1'b0;
		end else if (atLimit) begin
			gapCount <= 32'h0000_0000;
			failPulse <= 1'b1;
		end else begin
			gapCount <= gapCount + 32'h0000_0001;
			failPulse <= 1'b0;
		end
	end
endmodule : edge_watchdog

// >>> verif/osc_model.sv
// Oscillator sources that stand still low while disabled
`timescale 1ns/100ps
module osc_model (
	input wire logic precOscEn,
	input wire logic xtalEn,
	input wire logic wdogEn,
	input wire logic wdogStop,
	output logic precOscClk,
	output logic xtalClk,
	output logic wdogClk,
	output logic extClk
);
	initial begin
		precOscClk = 1'b0;
		xtalClk = 1'b0;
		wdogClk = 1'b0;
		extClk = 1'b0;
	end
	always #21.7 precOscClk = precOscEn & ~precOscClk;
	// Crystal pin carries the undivided crystal clock
	always #50.3 xtalClk = xtalEn & ~xtalClk;
	// Stop command models a dead watchdog oscillator
	always #200.9 wdogClk = wdogEn & ~wdogStop & ~wdogClk;
	always #99.1 extClk = ~extClk;
endmodule : osc_model

// >>> verif/test_clock_failure_monitor.sv
// Register-level test of the clock failure monitor
`timescale 1ns/100ps
module test_clock_failure_monitor;
	import clock_failure_monitor_pkg::*;
	localparam int LIMIT = 40000;
	logic clk_sys, rst;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [1:0] xtalModeOption, xtalMode, activeSource;
	logic xtalPin, precOscClk, wdogClk, extClk, xtalOff, precOscOn;
	logic xtalEnable, wdogOscEnable, clkFailEvent, irq, wdogStop;
	int err_count, comparisons, cyc, n;

	clock_failure_monitor i_clock_failure_monitor (
		.clk_sys(clk_sys), .rst(rst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .crystal_input_pin(xtalPin),
		.precOscClk(precOscClk), .wdogClk(wdogClk), .extClk(extClk),
		.xtalModeOption(xtalModeOption), .crystal_disable_option(xtalOff),
		.internal_precision_osc(precOscOn), .xtalEnable(xtalEnable),
		.wdogOscEnable(wdogOscEnable), .xtalMode(xtalMode),
		.activeSource(activeSource), .clkFailEvent(clkFailEvent),
		.irq(irq)
	);

	osc_model i_osc_model (
		.precOscEn(precOscOn), .xtalEn(xtalEnable),
		.wdogEn(wdogOscEnable), .wdogStop(wdogStop),
		.precOscClk(precOscClk), .xtalClk(xtalPin),
		.wdogClk(wdogClk), .extClk(extClk)
	);

	always #4 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc >= LIMIT) begin
			err_count++;
			stop_test();
		end
	end

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task rd32(input logic [7:0] a);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd32

	task stop_test();
		$display("err_count %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : stop_test

	initial begin
		{clk_sys, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, wdogStop} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hF;
		xtalModeOption = 2'h0;
		xtalOff = 1'b1;
		rst = 1'b1;
		{err_count, comparisons, cyc, n} = 0;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		rd32(ADDR_CTRL);
		chk("ctrl reset", CTRL_RESET, rd);
		chk("prec osc on", 32'h1, precOscOn);
		chk("xtal off", 32'h0, xtalEnable);
		rd32(ADDR_IRQ_MASK);
		chk("mask reset", 32'h0, rd);
		rd32(8'h10);
		chk("rd resp", 32'h2, resp);
		chk("rd data", 32'h0, rd);
		wr(8'h14, 32'h0000_0001);
		chk("wr resp", 32'h2, resp);
		for (int m = 0; m < 4; m++) begin
			xtalModeOption <= m[1:0];
			repeat (3) @(posedge clk_sys);
			chk("xtal mode", m, xtalMode);
		end
		// Crystal on, detectors off, settle before selecting it
		wr(ADDR_CTRL, 32'h0000_0003);
		repeat (1000) @(posedge xtalPin);
		chk("xtal on", 32'h1, xtalEnable);
		wr(ADDR_CTRL, 32'h0000_0023);
		do rd32(ADDR_STATUS); while (rd[1:0] !== SRC_XTAL && ++n < 20);
		chk("status src", SRC_XTAL, rd[1:0]);
		chk("src port", SRC_XTAL, activeSource);
		chk("prec osc kept", 32'h1, precOscOn);
		wr(ADDR_CTRL, 32'h0000_003F);
		repeat (2000) @(posedge clk_sys);
		chk("wdog osc on", 32'h1, wdogOscEnable);
		rd32(ADDR_IRQ_STAT);
		chk("no fail", 32'h0, rd);
		wdogStop <= 1'b1;
		n = 0;
		while (clkFailEvent !== 1'b1) begin
			@(posedge clk_sys);
			n++;
		end
		chk("wd gap", 32'h1, n >= WDFAIL_CYCLES - 52 && n <= WDFAIL_CYCLES + 8);
		chk("src kept", SRC_XTAL, activeSource);
		rd32(ADDR_STATUS);
		chk("wd failed", 32'h1, rd[5]);
		rd32(ADDR_IRQ_STAT);
		chk("irq stat", 32'h2, rd);
		chk("irq masked", 32'h0, irq);
		wr(ADDR_IRQ_MASK, 32'h0000_0002);
		rd32(ADDR_IRQ_MASK);
		chk("mask", 32'h2, rd);
		chk("irq on", 32'h1, irq);
		wr(ADDR_IRQ_STAT, 32'h0000_0002);
		rd32(ADDR_IRQ_STAT);
		chk("stat clr", 32'h0, rd);
		chk("irq off", 32'h0, irq);
		wr(ADDR_CTRL, 32'h0000_002F);
		rd32(ADDR_CTRL);
		chk("ctrl", 32'h2F, rd);
		// Slow external source taken with the primary detector kept off
		wr(ADDR_CTRL, 32'h0000_0027);
		wr(ADDR_CTRL, 32'h0000_0067);
		rd32(ADDR_STATUS);
		chk("ext src", SRC_EXT, rd[1:0]);
		chk("ext port", SRC_EXT, activeSource);
		stop_test();
	end
endmodule : test_clock_failure_monitor
